// File: hdl/asp_top.v
// APB-mapped four-mode serial port with shift mode and framed modes.
`timescale 1ns/1ps
`include "asp_defs.vh"

// What this block does
// - Framed modes transmit and receive simultaneously; mode 0 does one at a time.
// - Receive double buffered; late read loses byte.
// - Buffer write feeds transmitter; read returns receiver.
// - Mode 0: shift clock out, 8 bits LSB-first.
// - Mode 1: start, 8 data, stop; variable rate.
// - Mode 1 stores stop bit as ninth bit.
// - Mode 2: eleven bits, ninth from control.
// - Modes 2/3 store ninth bit, ignore stop.
// - Mode 2 rate: oscillator/32 or /64.
// - Mode 3: mode 2 framing, variable rate.
// - A buffer write starts a transmission unless the engine is busy.
// - Mode 0 receive needs flag clear, enable.
// - Framed receive starts on start bit, enabled.
// - Address filter: modes 2/3 accept only ninth bit one.
module asp_top (
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        rst,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Timer overflow tick for modes 1 and 3.
   input  wire        baud_tick,
   // Serial pins.
   input  wire        rxd_in,
   output reg         rxd_out,
   output reg         rxd_oe,
   output wire        txd_out,
   // Interrupt.
   output wire        irq
);

   localparam [2:0] M0_IDLE = 3'b001;
   localparam [2:0] M0_TX   = 3'b010;
   localparam [2:0] M0_RX   = 3'b100;

   // Last divider count of each mode 2 rate; the tick falls on count zero.
   localparam integer DIV32_LAST = `ASP_DIV32_TICK - 1;
   localparam integer DIV64_LAST = `ASP_DIV64_TICK - 1;

   // Register file.
   reg  [6:0]  ctl_r;
   reg  [2:0]  stat_r;
   reg  [2:0]  stat_nxt;
   reg  [2:0]  mask_r;
   reg  [7:0]  rx_hold_r;
   reg  [7:0]  tx_data_r;

   // Rate generation.
   reg  [1:0]  div_r;
   reg         tick16;

   // Mode 0 shift engine.
   reg  [2:0]  m0_st_r;
   reg  [3:0]  m0_ph_r;
   reg  [2:0]  m0_bit_r;
   reg  [7:0]  m0_sh_r;
   reg         m0_tx_done;
   reg         m0_rx_done;
   reg         ftx_go_r;

   wire [1:0]  mode;
   wire        nine;
   wire        wr_en;
   wire        rd_setup;
   wire        sel_buf;
   wire        sel_ctl;
   wire        sel_stat;
   wire        sel_mask;
   wire        buf_wr;
   wire        ftx_busy;
   wire        ftx_done;
   wire        ftx_txd;
   wire        frx_busy;
   wire        frx_done;
   wire [7:0]  frx_data;
   wire        frx_bit9;
   wire        frx_keep;
   wire        m0_sclk;
   wire        m0_busy;
   wire        rx_set;
   wire        ovr_set;
   wire        m0_rx_ok;
   wire        tx_busy_any;
   wire        rx_busy_any;
   wire [1:0]  div_last;

   assign mode = ctl_r[`ASP_CTL_MODE_HI:`ASP_CTL_MODE_LO];
   assign nine = mode[1];

   // APB decode; every access completes without wait states.
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign sel_buf  = (paddr == `ASP_OFS_BUFFER);
   assign sel_ctl  = (paddr == `ASP_OFS_CONTROL);
   assign sel_stat = (paddr == `ASP_OFS_STATUS);
   assign sel_mask = (paddr == `ASP_OFS_MASK);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !(sel_buf || sel_ctl || sel_stat || sel_mask);

   assign buf_wr = wr_en && sel_buf;

   // Busy bits cover both engines, so software sees one view per direction.
   assign tx_busy_any = ftx_busy || (m0_st_r == M0_TX);
   assign rx_busy_any = frx_busy || (m0_st_r == M0_RX);

   // Read data is captured in the setup cycle and stands through the access.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         if (sel_buf) begin
            prdata[7:0] <= rx_hold_r;
         end
         if (sel_ctl) begin
            prdata[6:0] <= ctl_r;
         end
         if (sel_stat) begin
            prdata[2:0]              <= stat_r;
            prdata[`ASP_ST_TXBUSY]   <= tx_busy_any;
            prdata[`ASP_ST_RXBUSY]   <= rx_busy_any;
         end
         if (sel_mask) begin
            prdata[2:0] <= mask_r;
         end
      end
   end

   // Control and mask registers; the received ninth bit is hardware owned.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl_r  <= `ASP_CTL_RESET;
         mask_r <= `ASP_MASK_RESET;
      end else begin
         if (wr_en && sel_ctl) begin
            ctl_r[5:0] <= pwdata[5:0];
         end
         if (wr_en && sel_mask) begin
            mask_r <= pwdata[2:0];
         end
         if (rx_set) begin
            // ninth bit or stop bit stored; a mode 0 receive clears it
            ctl_r[`ASP_CTL_RXNINE] <= frx_done ? frx_bit9 : 1'b0;
         end
      end
   end

   // Transmit data latch for the framed engine; mode 0 loads its shifter from the bus.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_data_r <= 8'h00;
      end else if (buf_wr && !m0_busy && !ftx_busy) begin
         tx_data_r <= pwdata[7:0];
      end
   end

   assign div_last = ctl_r[`ASP_CTL_RATE] ? DIV32_LAST[1:0] : DIV64_LAST[1:0];

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r <= 2'h0;
      end else if (div_r == div_last) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   always @* begin
      case (mode)
         `ASP_MODE_9FIX: tick16 = (div_r == 2'h0);
         `ASP_MODE_8BIT: tick16 = baud_tick;
         `ASP_MODE_9VAR: tick16 = baud_tick;
         default:        tick16 = 1'b0;
      endcase
   end

   // Framed start is delayed one cycle so the data latch is settled.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ftx_go_r <= 1'b0;
      end else begin
         ftx_go_r <= buf_wr && (mode != `ASP_MODE_SHIFT) && !ftx_busy;
      end
   end

   asp_tx asp_tx_inst (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick16),
      .start   (ftx_go_r),
      .nine    (nine),
      .data    ({ctl_r[`ASP_CTL_TXNINE], tx_data_r}),
      .busy    (ftx_busy),
      .done    (ftx_done),
      .txd     (ftx_txd)
   );

   asp_rx asp_rx_inst (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick16),
      .en      (ctl_r[`ASP_CTL_REN]),
      .nine    (nine),
      .rxd     (rxd_in),
      .busy    (frx_busy),
      .done    (frx_done),
      .data    (frx_data),
      .bit9    (frx_bit9)
   );

   // Mode 0: the shift clock is low for the first half of each bit.
   assign m0_busy = (m0_st_r != M0_IDLE);
   assign m0_sclk = !m0_busy || (m0_ph_r >= `ASP_SHIFT_HALF);

   // The flag of a receive that just ended is set one cycle late
   // so the done pulse itself also blocks an immediate restart.
   assign m0_rx_ok = ctl_r[`ASP_CTL_REN] && !stat_r[`ASP_ST_RXDONE] && !m0_rx_done;

   // shift clock drives the output pin in mode 0, the framed transmitter in modes 1 to 3
   assign txd_out = (mode == `ASP_MODE_SHIFT) ? m0_sclk : ftx_txd;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         m0_st_r    <= M0_IDLE;
         m0_ph_r    <= 4'h0;
         m0_bit_r   <= 3'h0;
         m0_sh_r    <= 8'h00;
         m0_tx_done <= 1'b0;
         m0_rx_done <= 1'b0;
      end else begin
         m0_tx_done <= 1'b0;
         m0_rx_done <= 1'b0;
         case (m0_st_r)
            M0_IDLE: begin
               m0_ph_r  <= 4'h0;
               m0_bit_r <= 3'h0;
               if (mode == `ASP_MODE_SHIFT) begin
                  if (buf_wr) begin
                     m0_sh_r <= pwdata[7:0];
                     m0_st_r <= M0_TX;
                  end else if (m0_rx_ok) begin
                     m0_st_r <= M0_RX;
                  end
               end
            end
            M0_TX, M0_RX: begin
               // Receive samples on the rising shift clock edge.
               if (m0_st_r == M0_RX && m0_ph_r == `ASP_SHIFT_HALF) begin
                  m0_sh_r <= {rxd_in, m0_sh_r[7:1]};
               end
               if (m0_ph_r == `ASP_SHIFT_DIV - 1) begin
                  m0_ph_r  <= 4'h0;
                  m0_bit_r <= m0_bit_r + 3'h1;
                  if (m0_st_r == M0_TX) begin
                     m0_sh_r <= {1'b1, m0_sh_r[7:1]};
                  end
                  if (m0_bit_r == 3'h7) begin
                     m0_tx_done <= (m0_st_r == M0_TX);
                     m0_rx_done <= (m0_st_r == M0_RX);
                     m0_st_r    <= M0_IDLE;
                  end
               end else begin
                  m0_ph_r <= m0_ph_r + 4'h1;
               end
            end
            default: begin
               m0_st_r <= M0_IDLE;
            end
         endcase
      end
   end

   // Data pin is driven only while mode 0 shifts out.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxd_out <= 1'b1;
         rxd_oe  <= 1'b0;
      end else begin
         rxd_out <= (m0_st_r == M0_TX) ? m0_sh_r[0] : 1'b1;
         rxd_oe  <= (m0_st_r == M0_TX);
      end
   end

   // address filter drops 9-bit frames with ninth bit clear
   assign frx_keep = !(nine && ctl_r[`ASP_CTL_AFE] && !frx_bit9);

   // second byte lost while the first is unread
   assign ovr_set = frx_done && frx_keep && stat_r[`ASP_ST_RXDONE];
   assign rx_set  = (frx_done && frx_keep && !stat_r[`ASP_ST_RXDONE]) || m0_rx_done;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_hold_r <= 8'h00;
      end else if (rx_set) begin
         rx_hold_r <= frx_done ? frx_data : m0_sh_r;
      end
   end

   // sticky flags, a set wins over a clear
   always @* begin
      stat_nxt = stat_r;
      if (wr_en && sel_stat) begin
         stat_nxt = stat_r & ~pwdata[2:0];
      end
      if (ftx_done || m0_tx_done) begin
         stat_nxt[`ASP_ST_TXDONE] = 1'b1;
      end
      if (rx_set) begin
         stat_nxt[`ASP_ST_RXDONE] = 1'b1;
      end
      if (ovr_set) begin
         stat_nxt[`ASP_ST_OVERRUN] = 1'b1;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_r <= `ASP_ST_RESET;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   assign irq = |(stat_r & mask_r);

endmodule

// File: hdl/asp_defs.vh
// Constants for the four-mode asynchronous serial port.
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH

// Register byte offsets.
`define ASP_OFS_BUFFER   12'h000
`define ASP_OFS_CONTROL  12'h004
`define ASP_OFS_STATUS   12'h008
`define ASP_OFS_MASK     12'h00c

// Control field positions.
`define ASP_CTL_MODE_LO  0
`define ASP_CTL_MODE_HI  1
`define ASP_CTL_RATE     2
`define ASP_CTL_AFE      3
`define ASP_CTL_REN      4
`define ASP_CTL_TXNINE   5
`define ASP_CTL_RXNINE   6
`define ASP_CTL_RESET    7'h00

// Status field positions, sticky flags cleared by writing one.
`define ASP_ST_TXDONE    0
`define ASP_ST_RXDONE    1
`define ASP_ST_OVERRUN   2
`define ASP_ST_TXBUSY    3
`define ASP_ST_RXBUSY    4
`define ASP_ST_RESET     3'h0
`define ASP_MASK_RESET   3'h0

// Mode codes.
`define ASP_MODE_SHIFT   2'h0
`define ASP_MODE_8BIT    2'h1
`define ASP_MODE_9FIX    2'h2
`define ASP_MODE_9VAR    2'h3

// Timing counts; shift and divider counts in oscillator cycles, sample counts in ticks.
`define ASP_SHIFT_DIV    12
`define ASP_SHIFT_HALF   6
`define ASP_DIV32_TICK   2
`define ASP_DIV64_TICK   4
`define ASP_OVERSAMPLE   16
`define ASP_SAMPLE_PHASE 8

`endif

// File: hdl/asp_tx.v
// Framed transmitter for the 10-bit and 11-bit asynchronous modes.
`timescale 1ns/1ps
`include "asp_defs.vh"

module asp_tx (
   // Clock and reset.
   input  wire       sys_clk,
   input  wire       rst,
   // Oversample tick and frame request.
   input  wire       tick,
   input  wire       start,
   input  wire       nine,
   input  wire [8:0] data,
   // Status and line.
   output wire       busy,
   output reg        done,
   output wire       txd
);

   reg  [10:0] sh_r;
   reg  [3:0]  ph_r;
   reg  [3:0]  left_r;

   assign busy = (left_r != 4'h0);
   assign txd  = busy ? sh_r[0] : 1'b1;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sh_r   <= 11'h7ff;
         ph_r   <= 4'h0;
         left_r <= 4'h0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            // Start bit low, data LSB first, optional ninth bit, stop high.
            sh_r   <= nine ? {1'b1, data[8], data[7:0], 1'b0}
                           : {2'b11, data[7:0], 1'b0};
            left_r <= nine ? 4'd11 : 4'd10;
            ph_r   <= 4'h0;
         end else if (busy && tick) begin
            ph_r <= ph_r + 4'h1;
            if (ph_r == 4'hf) begin
               sh_r   <= {1'b1, sh_r[10:1]};
               left_r <= left_r - 4'h1;
               done   <= (left_r == 4'h1);
            end
         end
      end
   end

endmodule

// File: hdl/asp_rx.v
// Framed receiver with start-bit detection and mid-bit sampling.
`timescale 1ns/1ps
`include "asp_defs.vh"

module asp_rx (
   // Clock and reset.
   input  wire       sys_clk,
   input  wire       rst,
   // Oversample tick, enable and line.
   input  wire       tick,
   input  wire       en,
   input  wire       nine,
   input  wire       rxd,
   // Received frame.
   output wire       busy,
   output reg        done,
   output reg  [7:0] data,
   output reg        bit9
);

   reg  [9:0] sh_r;
   reg  [3:0] ph_r;
   reg  [3:0] idx_r;
   reg        act_r;

   assign busy = act_r;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sh_r  <= 10'h000;
         ph_r  <= 4'h0;
         idx_r <= 4'h0;
         act_r <= 1'b0;
         done  <= 1'b0;
         data  <= 8'h00;
         bit9  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!act_r) begin
            // A low line at a tick is taken as a start bit.
            if (en && tick && !rxd) begin
               act_r <= 1'b1;
               ph_r  <= 4'h1;
               idx_r <= 4'h0;
            end
         end else if (tick) begin
            ph_r <= ph_r + 4'h1;
            if (ph_r == `ASP_SAMPLE_PHASE) begin
               if (idx_r == 4'h0 && rxd) begin
                  // Glitch, not a start bit.
                  act_r <= 1'b0;
               end else begin
                  sh_r  <= {rxd, sh_r[9:1]};
                  idx_r <= idx_r + 4'h1;
                  if (idx_r == (nine ? 4'd10 : 4'd9)) begin
                     act_r <= 1'b0;
                     done  <= 1'b1;
                     // Ninth bit, or the stop bit for 10-bit frames.
                     data  <= nine ? sh_r[8:1] : sh_r[9:2];
                     bit9  <= nine ? sh_r[9] : rxd;
                  end
               end
            end
         end
      end
   end

endmodule

// File: dv/asp_top_properties.sv
// Port-level assertions for the serial port top.
`timescale 1ns/1ps
module asp_top_checker (
   // Clock, reset and bus.
   input wire        sys_clk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins.
   input wire        baud_tick,
   input wire        rxd_in,
   input wire        rxd_out,
   input wire        rxd_oe,
   input wire        txd_out,
   input wire        irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   wire acc = psel && penable;
   wire hit = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);

   a_ready_no_wait: assert property (acc |-> pready)
      else $error("pready low in access");
   a_mapped_no_err: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped address");
   a_unmapped_err: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped address");
   a_unmapped_zero: assert property (acc && !hit && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_mask_off_quiet: assert property (acc && pwrite && paddr == 12'h00c
      && pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq with all masked");
   a_shift_low_six: assert property (rxd_oe && $fell(txd_out) |->
      (!txd_out)[*6] ##1 txd_out)
      else $error("shift clock low phase wrong");
   a_shift_high_six: assert property (rxd_oe && $rose(txd_out) |-> txd_out[*6])
      else $error("shift clock high phase wrong");
   a_data_on_low: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out)
      |-> !txd_out)
      else $error("data moved while clock high");
   a_oe_clocks: assert property ($rose(rxd_oe) |-> ##[0:12] !txd_out)
      else $error("no shift clock while driving");
   a_irq_sticky: assert property (irq && !(psel && penable && pwrite) |=> irq)
      else $error("irq dropped without a write");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
endmodule

bind asp_top asp_top_checker asp_top_checker_inst (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .baud_tick(baud_tick), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
   .txd_out(txd_out), .irq(irq)
);

// File: dv/asp_peer.sv
// Remote serial peer: sends frames and decodes framed or shifted output.
`timescale 1ns/1ps
module asp_peer (
   // Clock and lines.
   input  wire sys_clk,
   input  wire txd_out,
   input  wire rxd_out,
   input  wire rxd_oe,
   output reg  line
);
   initial line = 1'b1;

   task automatic send(input [9:0] f, input integer nb, input integer bc);
      integer i;
      begin
         line <= 1'b0;
         repeat (bc) @(posedge sys_clk);
         for (i = 0; i < nb; i = i + 1) begin
            line <= f[i];
            repeat (bc) @(posedge sys_clk);
         end
         line <= 1'b1;
      end
   endtask

   // Samples each bit in its middle after the start edge.
   task automatic recv(input integer nb, input integer bc, output [9:0] f);
      integer i;
      begin
         f = 10'h000;
         @(negedge txd_out);
         repeat (bc / 2) @(posedge sys_clk);
         for (i = 0; i < nb; i = i + 1) begin
            repeat (bc) @(posedge sys_clk);
            f[i] = txd_out;
         end
      end
   endtask

   // Shifted data is valid at the rising clock.
   task automatic shift_in(output [7:0] d);
      integer i;
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge txd_out);
         while (!rxd_oe) @(posedge txd_out);
         d[i] = rxd_out;
      end
   endtask

   task automatic shift_out(input [7:0] d);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            @(negedge txd_out);
            line <= d[i];
         end
         @(posedge txd_out);
         repeat (2) @(posedge sys_clk);
         line <= 1'b1;
      end
   endtask
endmodule

// File: dv/tb_asp_top.sv
// Self-checking bench for the four-mode serial port.
`timescale 1ns/1ps
module tb_asp_top;
   reg         sys_clk;
   reg         rst;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   reg         baud_tick;
   wire        rxd_in;
   wire        rxd_out;
   wire        rxd_oe;
   wire        txd_out;
   wire        irq;
   wire        line;
   reg  [1:0]  tdiv;
   reg  [31:0] rd;
   reg         err;
   reg  [9:0]  f;
   integer     num_errors;
   integer     comparisons;
   integer     cycles;
   integer     i;

   assign rxd_in = rxd_oe ? rxd_out : line;

   asp_top asp_top_inst (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .baud_tick(baud_tick), .rxd_in(rxd_in), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
   asp_peer asp_peer_inst (.sys_clk(sys_clk), .txd_out(txd_out), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .line(line));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Timer tick every four cycles, so one bit lasts 64 cycles.
   always @(posedge sys_clk) begin
      tdiv <= tdiv + 2'h1;
      baud_tick <= (tdiv == 2'h3);
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors = num_errors + 1;
         conclude;
      end
   end

   task conclude;
      begin
         $display("errors=%0d comparisons=%0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task xfer(input [11:0] a, input w, input [31:0] d);
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         @(posedge sys_clk);
         while (pready !== 1'b1) @(posedge sys_clk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task wr(input [11:0] a, input [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task rc(input [11:0] a, input [31:0] exp);
      begin
         xfer(a, 1'b0, 32'h0);
         chk(rd, exp);
      end
   endtask

   task wait_st(input [31:0] b);
      integer n;
      begin
         n = 0;
         rd = 32'h0;
         while ((rd & b) !== b && n < 100) begin
            xfer(12'h008, 1'b0, 32'h0);
            n = n + 1;
            repeat (8) @(posedge sys_clk);
         end
      end
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      baud_tick = 1'b0;
      tdiv = 2'h0;
      cycles = 0;
      num_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rc(12'h004, 32'h0);
      rc(12'h008, 32'h0);
      xfer(12'h010, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(12'h004, 32'h11);
      wr(12'h00c, 32'h3);
      fork
         asp_peer_inst.send(10'h33c, 9, 64);
         asp_peer_inst.recv(9, 64, f);
         begin
            wr(12'h000, 32'ha5);
            wr(12'h000, 32'hff);
         end
      join
      chk({22'h0, f}, 32'h1a5);
      wait_st(32'h3);
      rc(12'h008, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rc(12'h000, 32'h3c);
      rc(12'h004, 32'h51);
      wr(12'h008, 32'h3);
      rc(12'h008, 32'h0);
      asp_peer_inst.send(10'h311, 9, 64);
      wait_st(32'h2);
      asp_peer_inst.send(10'h322, 9, 64);
      repeat (40) @(posedge sys_clk);
      rc(12'h008, 32'h6);
      rc(12'h000, 32'h11);
      wr(12'h00c, 32'h4);
      chk({31'h0, irq}, 32'h1);
      wr(12'h00c, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(12'h008, 32'h7);
      wr(12'h004, 32'h01);
      asp_peer_inst.send(10'h344, 9, 64);
      rc(12'h008, 32'h0);
      wr(12'h004, 32'h1b);
      asp_peer_inst.send(10'h255, 10, 64);
      rc(12'h008, 32'h0);
      asp_peer_inst.send(10'h366, 10, 64);
      wait_st(32'h2);
      rc(12'h000, 32'h66);
      rc(12'h004, 32'h5b);
      wr(12'h008, 32'h2);
      wr(12'h004, 32'h13);
      asp_peer_inst.send(10'h277, 10, 64);
      wait_st(32'h2);
      rc(12'h004, 32'h13);
      wr(12'h008, 32'h2);
      for (i = 0; i < 2; i = i + 1) begin
         wr(12'h004, (i == 1) ? 32'h26 : 32'h02);
         fork
            asp_peer_inst.recv(10, (i == 1) ? 32 : 64, f);
            wr(12'h000, 32'h5a);
         join
         chk({22'h0, f}, {22'h0, 1'b1, i[0], 8'h5a});
         wait_st(32'h1);
         wr(12'h008, 32'h1);
      end
      wr(12'h004, 32'h00);
      fork
         asp_peer_inst.shift_in(f[7:0]);
         wr(12'h000, 32'h96);
      join
      chk({24'h0, f[7:0]}, 32'h96);
      wait_st(32'h1);
      wr(12'h008, 32'h1);
      fork
         asp_peer_inst.shift_out(8'hc3);
         wr(12'h004, 32'h10);
      join
      wait_st(32'h2);
      rc(12'h000, 32'hc3);
      rc(12'h008, 32'h2);
      repeat (200) @(posedge sys_clk);
      rc(12'h008, 32'h2);
      rc(12'h000, 32'hc3);
      conclude;
   end
endmodule
